// ===== dcd_defs.vh
// dcd_defs.vh
// constants for the dummy cycle setting descriptor: field positions,
// encodings, reset values and lane mode codes.
// assumes it is included by bare name from the design files.
`ifndef DCD_DEFS_VH
`define DCD_DEFS_VH

// ---------------------------------------------------------------
// descriptor field positions
// ---------------------------------------------------------------
`define DCD_SUPPORT_BIT     31
`define DCD_WIDTH_HI        30
`define DCD_WIDTH_LO        29
`define DCD_ADDRESSED_BIT   28
`define DCD_BYTE1_BIT       27
`define DCD_LSB_HI          26
`define DCD_LSB_LO          24
`define DCD_ADDR_HI         23
`define DCD_ADDR_LO         16
`define DCD_FLAG_8D8D8D     23
`define DCD_FLAG_8S8S8S     22
`define DCD_FLAG_4S4D4D     21
`define DCD_FLAG_4S4S4S     20
`define DCD_DUMMY_HI        19
`define DCD_DUMMY_LO        16
`define DCD_RD_OP_HI        15
`define DCD_RD_OP_LO        8
`define DCD_WR_OP_HI        7
`define DCD_WR_OP_LO        0

// ---------------------------------------------------------------
// encodings and reset values
// ---------------------------------------------------------------
`define DCD_MIN_BITS        3'h2
`define DCD_MAX_BITS        3'h5
`define DCD_REG_BITS        4'h8
`define DCD_DESC_RESET      32'h0000_0000
`define DCD_DUMMY_NONE      4'h0

// lane modes presented on active_mode
`define DCD_MODE_111        3'h0
`define DCD_MODE_4S4S4S     3'h1
`define DCD_MODE_4S4D4D     3'h2
`define DCD_MODE_8S8S8S     3'h3
`define DCD_MODE_8D8D8D     3'h4

`endif

// ===== dcd_word_pack.v
// dcd_word_pack.v
// combinational packing of the checked settings into the descriptor word.
// assumes the caller has already validated every field it presents.
`timescale 1ns/1ps
`include "dcd_defs.vh"

module dcd_word_pack (
  input  wire        support,
  input  wire [1:0]  width_code,
  input  wire        addressed,
  input  wire        byte1_place,
  input  wire [2:0]  lsb_pos,
  input  wire [7:0]  local_addr,
  input  wire [3:0]  mode_flags,
  input  wire [3:0]  dummy_count,
  input  wire [7:0]  read_opcode,
  input  wire [7:0]  write_opcode,
  output reg  [31:0] word
);

  // ---------------------------------------------------------------
  // field assembly
  // ---------------------------------------------------------------
  // bits 23-16 carry the local address or the mode flags with dummy count
  always @* begin
    word = `DCD_DESC_RESET;
    word[`DCD_SUPPORT_BIT]                = support;
    word[`DCD_WIDTH_HI:`DCD_WIDTH_LO]     = width_code;
    word[`DCD_ADDRESSED_BIT]              = addressed;
    word[`DCD_BYTE1_BIT]                  = byte1_place;
    word[`DCD_LSB_HI:`DCD_LSB_LO]         = lsb_pos;
    if (addressed) begin
      word[`DCD_ADDR_HI:`DCD_ADDR_LO]     = local_addr;
    end else begin
      word[`DCD_FLAG_8D8D8D]              = mode_flags[3];
      word[`DCD_FLAG_8S8S8S]              = mode_flags[2];
      word[`DCD_FLAG_4S4D4D]              = mode_flags[1];
      word[`DCD_FLAG_4S4S4S]              = mode_flags[0];
      word[`DCD_DUMMY_HI:`DCD_DUMMY_LO]   = dummy_count;
    end
    word[`DCD_RD_OP_HI:`DCD_RD_OP_LO]     = read_opcode;
    word[`DCD_WR_OP_HI:`DCD_WR_OP_LO]     = write_opcode;
  end

endmodule

// ===== dcd_descriptor.v
// dcd_descriptor.v
// device side source of the dummy cycle setting descriptor word.
// Behaviour
// - bit 31 set only when variable dummy supported
// - bits 30-29 encode two to five setting bits
// - bit 28 picks addressed or direct access
// - never byte-1 placement with 8-bit addressing
// - bits 26-24 give setting field lsb position
// - split or unordered field clears bit 31
// - direct mode flags in bits 23-20
// - 1-1-1 direct command uses no dummy cycles
//
// file holds the top module: configuration capture, consistency checks,
// the read-only descriptor register and the per-mode dummy count answer.
// assumes configuration inputs synchronous to clock and stable around
// the cycle in which they are taken.
`timescale 1ns/1ps
`include "dcd_defs.vh"

module dcd_descriptor (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        cfg_load,
  input  wire        cfg_var_dummy_en,
  input  wire        cfg_one_register,
  input  wire        cfg_contiguous,
  input  wire [2:0]  cfg_bit_count,
  input  wire        cfg_addressed,
  input  wire        cfg_byte1_place,
  input  wire        cfg_addr_8bit,
  input  wire [2:0]  cfg_lsb_pos,
  input  wire [7:0]  cfg_local_addr,
  input  wire [3:0]  cfg_mode_flags,
  input  wire [3:0]  cfg_dummy_count,
  input  wire [7:0]  cfg_read_opcode,
  input  wire [7:0]  cfg_write_opcode,
  input  wire [2:0]  active_mode,
  output wire [31:0] dummy_cycle_setting_descriptor,
  output wire        descriptor_valid,
  output wire [3:0]  cmd_dummy_count,
  output wire        cmd_mode_listed,
  output wire        cmd_read_ok,
  output wire        cmd_write_ok
);

  // ---------------------------------------------------------------
  // state machine codes
  // ---------------------------------------------------------------
  localparam [1:0] ST_CAPTURE = 2'h0;
  localparam [1:0] ST_PACK    = 2'h1;
  localparam [1:0] ST_READY   = 2'h2;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // bit count two to five maps onto a two bit code
  function [1:0] width_encode;
    input [2:0] bits;
    begin
      width_encode = bits[1:0] - 2'h2;
    end
  endfunction

  // true when the bit count can be expressed by the width field
  function width_legal;
    input [2:0] bits;
    begin
      width_legal = (bits >= `DCD_MIN_BITS) && (bits <= `DCD_MAX_BITS);
    end
  endfunction

  // true when a field of bits starting at lsb fits one byte register
  function field_fits;
    input [2:0] bits;
    input [2:0] lsb;
    begin
      field_fits = ({1'b0, lsb} + {1'b0, bits}) <= `DCD_REG_BITS;
    end
  endfunction

  // mode flag for a lane mode, clear for modes without a flag
  function mode_flag_of;
    input [2:0] mode;
    input [3:0] flags;
    begin
      case (mode)
        `DCD_MODE_8D8D8D: mode_flag_of = flags[3];
        `DCD_MODE_8S8S8S: mode_flag_of = flags[2];
        `DCD_MODE_4S4D4D: mode_flag_of = flags[1];
        `DCD_MODE_4S4S4S: mode_flag_of = flags[0];
        default:          mode_flag_of = 1'b0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         var_en_reg;
  reg         one_reg_reg;
  reg         contig_reg;
  reg  [2:0]  bit_count_reg;
  reg         addressed_reg;
  reg         byte1_reg;
  reg         addr_8bit_reg;
  reg  [2:0]  lsb_reg;
  reg  [7:0]  local_addr_reg;
  reg  [3:0]  mode_flags_reg;
  reg  [3:0]  dummy_reg;
  reg  [7:0]  rd_op_reg;
  reg  [7:0]  wr_op_reg;
  reg  [31:0] desc_reg;
  reg         valid_reg;
  reg  [3:0]  cmd_dummy_reg;
  reg         cmd_listed_reg;
  reg         cmd_rd_ok_reg;
  reg         cmd_wr_ok_reg;

  wire        support_ok;
  wire        byte1_ok;
  wire [1:0]  width_code;
  wire [31:0] packed_word;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // capture the straps after reset release, then on each cfg_load seen in ST_READY
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_CAPTURE: state_next = ST_PACK;
      ST_PACK:    state_next = ST_READY;
      ST_READY: begin
        if (cfg_load) begin
          state_next = ST_PACK;
        end
      end
      default:    state_next = ST_CAPTURE;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_CAPTURE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // configuration capture
  // ---------------------------------------------------------------
  // settings are taken in the capture state or on a load request seen in ST_READY
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      var_en_reg     <= 1'b0;
      one_reg_reg    <= 1'b0;
      contig_reg     <= 1'b0;
      bit_count_reg  <= 3'h0;
      addressed_reg  <= 1'b0;
      byte1_reg      <= 1'b0;
      addr_8bit_reg  <= 1'b0;
      lsb_reg        <= 3'h0;
      local_addr_reg <= 8'h00;
      mode_flags_reg <= 4'h0;
      dummy_reg      <= 4'h0;
      rd_op_reg      <= 8'h00;
      wr_op_reg      <= 8'h00;
    end else if (state_reg == ST_CAPTURE || (state_reg == ST_READY && cfg_load)) begin
      var_en_reg     <= cfg_var_dummy_en;
      one_reg_reg    <= cfg_one_register;
      contig_reg     <= cfg_contiguous;
      bit_count_reg  <= cfg_bit_count;
      addressed_reg  <= cfg_addressed;
      byte1_reg      <= cfg_byte1_place;
      addr_8bit_reg  <= cfg_addr_8bit;
      lsb_reg        <= cfg_lsb_pos;
      local_addr_reg <= cfg_local_addr;
      mode_flags_reg <= cfg_mode_flags;
      dummy_reg      <= cfg_dummy_count;
      rd_op_reg      <= cfg_read_opcode;
      wr_op_reg      <= cfg_write_opcode;
    end
  end

  // ---------------------------------------------------------------
  // consistency checks
  // ---------------------------------------------------------------
  // a layout the word cannot describe reports no support at all
  assign support_ok = var_en_reg
                    & one_reg_reg & contig_reg
                    & width_legal(bit_count_reg)
                    & field_fits(bit_count_reg, lsb_reg);
  // byte-1 placement is suppressed for 8-bit addressed parts
  assign byte1_ok   = byte1_reg & ~addr_8bit_reg;
  assign width_code = width_legal(bit_count_reg) ? width_encode(bit_count_reg) : 2'h0;

  dcd_word_pack u_pack (
    .support      (support_ok),
    .width_code   (width_code),
    .addressed    (addressed_reg),
    .byte1_place  (byte1_ok),
    .lsb_pos      (lsb_reg),
    .local_addr   (local_addr_reg),
    .mode_flags   (mode_flags_reg),
    .dummy_count  (dummy_reg),
    .read_opcode  (rd_op_reg),
    .write_opcode (wr_op_reg),
    .word         (packed_word)
  );

  // ---------------------------------------------------------------
  // read-only descriptor register
  // ---------------------------------------------------------------
  // word is refreshed in the pack state; valid drops while a reload runs
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      desc_reg  <= `DCD_DESC_RESET;
      valid_reg <= 1'b0;
    end else if (state_reg == ST_PACK) begin
      desc_reg  <= packed_word;
      valid_reg <= 1'b1;
    end else if (state_reg == ST_READY && cfg_load) begin
      valid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // per-mode answer for the direct command
  // ---------------------------------------------------------------
  // 1-1-1 never waits; listed modes use the word's dummy count
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_dummy_reg  <= `DCD_DUMMY_NONE;
      cmd_listed_reg <= 1'b0;
      cmd_rd_ok_reg  <= 1'b0;
      cmd_wr_ok_reg  <= 1'b0;
    end else begin
      cmd_rd_ok_reg  <= valid_reg && (desc_reg[`DCD_RD_OP_HI:`DCD_RD_OP_LO] != 8'h00);
      cmd_wr_ok_reg  <= valid_reg && (desc_reg[`DCD_WR_OP_HI:`DCD_WR_OP_LO] != 8'h00);
      if (!valid_reg || desc_reg[`DCD_ADDRESSED_BIT]) begin
        cmd_dummy_reg  <= `DCD_DUMMY_NONE;
        cmd_listed_reg <= 1'b0;
      end else if (active_mode == `DCD_MODE_111) begin
        cmd_dummy_reg  <= `DCD_DUMMY_NONE;
        cmd_listed_reg <= 1'b1;
      end else begin
        cmd_dummy_reg  <= desc_reg[`DCD_DUMMY_HI:`DCD_DUMMY_LO];
        cmd_listed_reg <= mode_flag_of(active_mode,
                                       desc_reg[`DCD_FLAG_8D8D8D:`DCD_FLAG_4S4S4S]);
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dummy_cycle_setting_descriptor = desc_reg;
  assign descriptor_valid               = valid_reg;
  assign cmd_dummy_count                = cmd_dummy_reg;
  assign cmd_mode_listed                = cmd_listed_reg;
  assign cmd_read_ok                    = cmd_rd_ok_reg;
  assign cmd_write_ok                   = cmd_wr_ok_reg;

endmodule

// ===== dcd_descriptor_assertions.sv
// dcd_descriptor_assertions.sv
// checker for the descriptor word fields and the direct command answer.
// assumes it is bound to dcd_descriptor and sees only its ports.
`timescale 1ns/1ps
module dcd_descriptor_checker (
  input wire        clock,
  input wire        reset_n,
  input wire        cfg_var_dummy_en,
  input wire        cfg_one_register,
  input wire        cfg_contiguous,
  input wire [2:0]  cfg_bit_count,
  input wire        cfg_addressed,
  input wire        cfg_byte1_place,
  input wire        cfg_addr_8bit,
  input wire [2:0]  cfg_lsb_pos,
  input wire [7:0]  cfg_local_addr,
  input wire [3:0]  cfg_mode_flags,
  input wire [2:0]  active_mode,
  input wire [31:0] dummy_cycle_setting_descriptor,
  input wire        descriptor_valid,
  input wire [3:0]  cmd_dummy_count,
  input wire        cmd_mode_listed
);
  wire [31:0] d;
  wire        direct;

  // short aliases for the word
  assign d      = dummy_cycle_setting_descriptor;
  assign direct = descriptor_valid & ~d[28];

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // a fresh word reflects the settings taken two edges back
  a_support_off_disabled: assert property (
    $rose(descriptor_valid) && !$past(cfg_var_dummy_en, 2) |-> !d[31])
    else $error("support flag set while disabled");
  a_split_field_clear: assert property (
    $rose(descriptor_valid) && !($past(cfg_one_register, 2) && $past(cfg_contiguous, 2))
    |-> !d[31]) else $error("support flag set for split field");
  a_width_code_match: assert property (
    $rose(descriptor_valid) && $past(cfg_bit_count, 2) inside {[3'h2:3'h5]}
    |-> d[30:29] == 2'($past(cfg_bit_count, 2) - 3'h2)) else $error("width code wrong");
  a_access_style_bit: assert property (
    $rose(descriptor_valid) |-> d[28] == $past(cfg_addressed, 2))
    else $error("access style bit wrong");
  a_no_byte1_narrow: assert property (
    $rose(descriptor_valid) && $past(cfg_addr_8bit, 2) |-> !d[27])
    else $error("byte one placement with 8-bit addressing");
  a_byte1_place_bit: assert property (
    $rose(descriptor_valid)
    |-> d[27] == ($past(cfg_byte1_place, 2) && !$past(cfg_addr_8bit, 2)))
    else $error("address placement bit wrong");
  a_local_addr_word: assert property (
    $rose(descriptor_valid) && $past(cfg_addressed, 2)
    |-> d[23:16] == $past(cfg_local_addr, 2))
    else $error("local address field wrong");
  a_lsb_field_pos: assert property (
    $rose(descriptor_valid) |-> d[26:24] == $past(cfg_lsb_pos, 2))
    else $error("lsb position wrong");
  a_mode_flags_word: assert property (
    $rose(descriptor_valid) && !$past(cfg_addressed, 2) |-> d[23:20] == $past(cfg_mode_flags, 2))
    else $error("mode flags wrong");
  a_direct_single_lane: assert property (
    direct && active_mode == 3'h0 |=> cmd_dummy_count == 4'h0 && cmd_mode_listed)
    else $error("single lane direct command has dummy cycles");
  a_quad_dummy_count: assert property (
    direct && active_mode == 3'h1 |=> cmd_dummy_count == $past(d[19:16]) &&
    cmd_mode_listed == $past(d[20])) else $error("quad dummy answer wrong");

  // main scenarios reached
  c_reload: cover property ($rose(descriptor_valid));
  c_supported: cover property (descriptor_valid && d[31]);
  c_octal_direct: cover property (direct && active_mode == 3'h4);
endmodule

// ===== dcd_host_model.sv
// dcd_host_model.sv
// host controller model that picks the lane mode of direct commands.
// assumes one clock shared with the descriptor block.
`timescale 1ns/1ps
module dcd_host_model (
  input  wire       clock,
  input  wire       reset_n,
  output reg  [2:0] active_mode
);
  // step through every mode code, unlisted ones too; a cleared flag is not a refusal
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active_mode <= 3'h0;
    end else begin
      active_mode <= active_mode + 3'h1;
    end
  end
endmodule

// ===== dcd_descriptor_tb_top.sv
// dcd_descriptor_tb_top.sv
// self-checking bench: random settings reloads, word and answer checks.
// assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin errors = errors + 1; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module dcd_descriptor_tb_top;
  reg         clock = 1'b0;
  reg         reset_n = 1'b0;
  reg         cfg_load = 1'b0;
  reg         en = 1'b1;
  reg         one = 1'b1;
  reg         ct = 1'b1;
  reg         ad = 1'b0;
  reg         b1 = 1'b1;
  reg         a8 = 1'b1;
  reg  [2:0]  bc = 3'h5;
  reg  [2:0]  ls = 3'h3;
  reg  [7:0]  la = 8'h3C;
  reg  [3:0]  fl = 4'hA;
  reg  [3:0]  dc = 4'hF;
  reg  [7:0]  ro = 8'h65;
  reg  [7:0]  wo = 8'h00;
  wire [2:0]  active_mode;
  wire [31:0] desc;
  wire        valid;
  wire [3:0]  cmd_dc;
  wire        listed;
  wire        rd_ok;
  wire        wr_ok;
  reg  [15:0] seed;
  reg  [31:0] r;
  reg  [31:0] ew;
  reg  [2:0]  m;
  integer     errors;
  integer     checks;
  integer     i;

  always #4 clock = ~clock;

  dcd_descriptor i_dcd_descriptor (.clock(clock), .reset_n(reset_n), .cfg_load(cfg_load),
    .cfg_var_dummy_en(en), .cfg_one_register(one), .cfg_contiguous(ct), .cfg_bit_count(bc),
    .cfg_addressed(ad), .cfg_byte1_place(b1), .cfg_addr_8bit(a8), .cfg_lsb_pos(ls),
    .cfg_local_addr(la), .cfg_mode_flags(fl), .cfg_dummy_count(dc), .cfg_read_opcode(ro),
    .cfg_write_opcode(wo), .active_mode(active_mode), .dummy_cycle_setting_descriptor(desc),
    .descriptor_valid(valid), .cmd_dummy_count(cmd_dc), .cmd_mode_listed(listed),
    .cmd_read_ok(rd_ok), .cmd_write_ok(wr_ok));
  dcd_host_model i_dcd_host_model (.clock(clock), .reset_n(reset_n), .active_mode(active_mode));

  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // expected word from the settings now presented
  function automatic [31:0] exp_word();
    reg       ok;
    reg [2:0] wc;
    ok = bc >= 3'h2 && bc <= 3'h5;
    wc = ok ? bc - 3'h2 : 3'h0;
    exp_word = {en & one & ct & ok & ({1'b0, ls} + {1'b0, bc} <= 4'h8), wc[1:0], ad,
                b1 & ~a8, ls, ad ? la : {fl, dc}, ro, wo};
  endfunction

  // expected {dummy, listed, read ok, write ok} for a mode
  function automatic [6:0] exp_cmd(input [2:0] mode);
    reg [3:0] dm;
    reg       lf;
    dm = (ew[28] || mode == 3'h0) ? 4'h0 : ew[19:16];
    lf = !ew[28] && (mode == 3'h0 || (mode <= 3'h4 && ew[19 + mode]));
    exp_cmd = {dm, lf, ew[15:8] != 8'h00, ew[7:0] != 8'h00};
  endfunction

  task complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // wait for the word, compare it, then sweep the mode answers
  task check_word;
    integer k;
    k = 0;
    while (valid !== 1'b1) begin
      if (k == 4) begin
        errors = errors + 1;
        complete_run;
      end
      k = k + 1;
      @(posedge clock);
      #1;
    end
    ew = exp_word();
    `CHK(desc, ew)
    repeat (9) begin
      m = active_mode;
      @(posedge clock);
      #1;
      `CHK({cmd_dc, listed, rd_ok, wr_ok}, exp_cmd(m))
    end
  endtask

  // present new settings with corner cases first, then take them
  task load(input integer n);
    seed = lfsr(seed);
    r[15:0] = seed;
    seed = lfsr(seed);
    r[31:16] = seed;
    @(posedge clock);
    en <= r[0] | r[1];
    one <= r[2] | r[3];
    ct <= r[4] | r[5];
    bc <= (n < 8) ? n[2:0] : ((n < 10) ? 3'h5 : r[8:6]);
    ls <= (n == 8) ? 3'h3 : ((n == 9) ? 3'h4 : r[14:12]);
    ad <= r[9];
    b1 <= r[10];
    a8 <= r[11];
    la <= r[22:15];
    fl <= r[26:23];
    dc <= r[30:27];
    ro <= (n % 5 == 0) ? 8'h00 : r[23:16];
    wo <= (n % 7 == 0) ? 8'h00 : r[7:0];
    cfg_load <= 1'b1;
    @(posedge clock);
    cfg_load <= 1'b0;
    #1;
    check_word;
  endtask

  // reset, first word, then random reloads
  initial begin
    errors = 0;
    checks = 0;
    seed = 16'h5B40;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    check_word;
    for (i = 0; i < 40; i = i + 1) begin
      load(i);
    end
    complete_run;
  end
endmodule

bind dcd_descriptor dcd_descriptor_checker i_checker (.clock(clock), .reset_n(reset_n),
  .cfg_var_dummy_en(cfg_var_dummy_en), .cfg_one_register(cfg_one_register),
  .cfg_contiguous(cfg_contiguous), .cfg_bit_count(cfg_bit_count),
  .cfg_addressed(cfg_addressed), .cfg_addr_8bit(cfg_addr_8bit), .cfg_lsb_pos(cfg_lsb_pos),
  .cfg_byte1_place(cfg_byte1_place), .cfg_local_addr(cfg_local_addr),
  .cfg_mode_flags(cfg_mode_flags), .active_mode(active_mode),
  .dummy_cycle_setting_descriptor(dummy_cycle_setting_descriptor),
  .descriptor_valid(descriptor_valid), .cmd_dummy_count(cmd_dummy_count),
  .cmd_mode_listed(cmd_mode_listed));
